//--- inc/swio_cmd_pkg.sv
/*
 * constants, enums and the byte carrier struct for the switching port command
 * handler; assumes ascii text lines ending in carriage return.
 */
package swio_cmd_pkg;

    // ==========================================================
    // byte stream carrier
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } byte_beat_t;

    // ==========================================================
    // port function and control states
    typedef enum logic [1:0] {
        FUNC_IN = 2'h0,
        FUNC_OUT = 2'h1,
        FUNC_PASSIVE = 2'h2
    } port_func_t;

    typedef enum logic [1:0] {
        ST_RECV = 2'h0,
        ST_PARSE = 2'h1,
        ST_SEND = 2'h3
    } ctl_state_t;

    localparam port_func_t FUNC_RESET = FUNC_PASSIVE;
    localparam logic [1:0] STATE_RESET = 2'h0;
    localparam int NUM_PORTS = 2;

    // ==========================================================
    // ascii characters
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_SP = 8'h20;
    localparam logic [7:0] CH_O = 8'h4F;
    localparam logic [7:0] CH_A = 8'h41;
    localparam logic [7:0] CH_D = 8'h44;
    localparam logic [7:0] CH_F = 8'h46;
    localparam logic [7:0] CH_S = 8'h53;
    localparam logic [7:0] CH_I = 8'h49;
    localparam logic [7:0] CH_P = 8'h50;
    localparam logic [7:0] CH_Q = 8'h3F;
    localparam logic [7:0] CH_EQ = 8'h3D;
    localparam logic [7:0] CH_SEMI = 8'h3B;
    localparam logic [7:0] CH_0 = 8'h30;
    localparam logic [7:0] CH_1 = 8'h31;
    localparam logic [7:0] CH_2 = 8'h32;

    // ==========================================================
    // status codes
    localparam logic [1:0] STS_OK = 2'h0;
    localparam logic [1:0] STS_SYNTAX = 2'h1;
    localparam logic [1:0] STS_PARAM = 2'h2;
    localparam logic [1:0] STS_OTHER = 2'h3;

    // ==========================================================
    // line layout, shared by commands and query replies
    localparam int LINE_MAX = 16;
    localparam int REPLY_MAX = 13;
    localparam int POS_OP0 = 0;
    localparam int POS_OP1 = 1;
    localparam int POS_ARG = 2;
    localparam int POS_F1_S = 3;
    localparam int POS_F1_NUM = 4;
    localparam int POS_F1_EQ = 5;
    localparam int POS_F1_VAL = 6;
    localparam int POS_SEP = 7;
    localparam int POS_F2_S = 8;
    localparam int POS_F2_NUM = 9;
    localparam int POS_F2_EQ = 10;
    localparam int POS_F2_VAL = 11;
    localparam int POS_ACK_D0 = 3;
    localparam int POS_ACK_D1 = 4;
    localparam int POS_ACK_CR = 5;
    localparam logic [4:0] LEN_BARE = 5'h02;
    localparam logic [4:0] LEN_SHORT = 5'h03;
    localparam logic [4:0] LEN_ONE = 5'h07;
    localparam logic [4:0] LEN_TWO = 5'h0C;
    localparam logic [3:0] RLEN_NONE = 4'h0;
    localparam logic [3:0] RLEN_ACK = 4'h6;
    localparam logic [3:0] RLEN_QUERY = 4'hD;

endpackage

//--- design/swio_cmd.sv
/*
 * text command handler for two switching ports: state query, set,
 * activate, deactivate, function query and function configuration.
 * assumes the host sends one line at a time ending in carriage return
 * and only while line_ready is high; replies drain under reply_ready.
 */
// Function
// RL1 - state query answers one character per port, separated by semicolon
// RL2 - characters: 0 low, 1 high, I for input, P for passive
// RL3 - states are logical; inverted port drives pin low when high
// RL4 - query reports output states last set by commands
// RL5 - set command with optional port fields drives addressed outputs
// RL6 - set value aimed at a non-output port is ignored
// RL7 - host lists addressed ports in ascending order
// RL8 - set command answered with status 00, 01, 02 or 03; the code never answers 03
// RL9 - deactivate port 1 or 2 drives it inactive, no answer
// RL10 - host deactivates only ports configured as outputs
// RL11 - activate port 1 or 2 drives it active, no answer
// RL12 - each port holds function input, output or passive
// RL13 - output state holds until a later command addresses it
module swio_cmd
    import swio_cmd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire byte_beat_t line_in,
    output logic line_ready,
    output byte_beat_t reply_out,
    input wire logic reply_ready,
    input wire logic [NUM_PORTS-1:0] port_invert,
    output logic [NUM_PORTS-1:0] port_drive,
    output logic [NUM_PORTS-1:0] port_drive_en
);

    // ==========================================================
    // state
    ctl_state_t state_reg, state_next;
    logic [7:0] line_mem [0:LINE_MAX-1];
    logic [7:0] reply_mem [0:REPLY_MAX-1];
    logic [7:0] reply_next [0:REPLY_MAX-1];
    logic [4:0] len_reg;
    logic overflow_reg;
    logic [3:0] rlen_reg, rlen_next, idx_reg;
    logic [NUM_PORTS-1:0] out_state_reg, out_state_next;
    port_func_t func_reg [0:NUM_PORTS-1];
    port_func_t func_next [0:NUM_PORTS-1];
    logic line_ready_reg;
    byte_beat_t reply_reg;
    logic [NUM_PORTS-1:0] drive_reg, drive_en_reg;

    // ==========================================================
    // receive decode
    wire take = line_in.valid && line_ready_reg;
    wire take_cr = take && line_in.data == CH_CR;
    wire take_chr = take && line_in.data != CH_CR;
    wire has_room = len_reg < 5'(LINE_MAX);

    // ==========================================================
    // line parse
    wire op_o = line_mem[POS_OP0] == CH_O;
    wire is_state_cmd = op_o && line_mem[POS_OP1] == CH_A;
    wire is_deact_cmd = op_o && line_mem[POS_OP1] == CH_D;
    wire is_func_cmd = op_o && line_mem[POS_OP1] == CH_F;
    wire len_short = len_reg == LEN_SHORT;
    wire arg_q = len_short && line_mem[POS_ARG] == CH_Q;
    wire arg_1 = len_short && line_mem[POS_ARG] == CH_1;
    wire arg_2 = len_short && line_mem[POS_ARG] == CH_2;
    wire f1_form = line_mem[POS_ARG] == CH_SP
        && line_mem[POS_F1_S] == CH_S
        && line_mem[POS_F1_EQ] == CH_EQ;
    wire f1_one = line_mem[POS_F1_NUM] == CH_1;
    wire f1_two = line_mem[POS_F1_NUM] == CH_2;
    // second field only after port one: descending order is a syntax error
    wire fields_two = len_reg == LEN_TWO && f1_form && f1_one
        && line_mem[POS_SEP] == CH_SEMI
        && line_mem[POS_F2_S] == CH_S
        && line_mem[POS_F2_NUM] == CH_2
        && line_mem[POS_F2_EQ] == CH_EQ; // RL7
    wire fields_one = len_reg == LEN_ONE && f1_form && (f1_one || f1_two);
    wire fields_none = len_reg == LEN_BARE;
    wire syntax_ok = fields_none || fields_one || fields_two;
    wire p1_has = (fields_one && f1_one) || fields_two;
    wire p2_has = (fields_one && f1_two) || fields_two;
    wire [7:0] p1_val = line_mem[POS_F1_VAL];
    wire [7:0] p2_val = fields_two ? line_mem[POS_F2_VAL]
                                   : line_mem[POS_F1_VAL];
    wire [NUM_PORTS-1:0] has = {p2_has, p1_has};
    wire [7:0] val [0:NUM_PORTS-1];
    assign val[0] = p1_val;
    assign val[1] = p2_val;

    // a line that overflowed the buffer is dropped without a reply;
    // a line shorter than a command word leaves the last line in the
    // buffer, which must not run a second time
    wire valid_line = !overflow_reg && len_reg >= LEN_BARE;
    wire do_state_query = valid_line && is_state_cmd && arg_q;
    wire do_func_query = valid_line && is_func_cmd && arg_q;
    wire do_act = valid_line && is_state_cmd && (arg_1 || arg_2);
    wire do_deact = valid_line && is_deact_cmd && (arg_1 || arg_2);
    wire do_state_set = valid_line && is_state_cmd && !arg_q && !arg_1
        && !arg_2;
    wire do_func_set = valid_line && is_func_cmd && !arg_q;
    wire [NUM_PORTS-1:0] sel_port = {arg_2, arg_1};

    // ==========================================================
    // value checks
    logic [NUM_PORTS-1:0] bit_ok, func_ok;
    port_func_t func_val [0:NUM_PORTS-1];
    always_comb begin
        for (int i = 0; i < NUM_PORTS; i++) begin
            bit_ok[i] = !has[i] || val[i] == CH_0 || val[i] == CH_1;
            func_ok[i] = !has[i] || val[i] == CH_I || val[i] == CH_O
                || val[i] == CH_P;
            func_val[i] = val[i] == CH_I ? FUNC_IN
                        : val[i] == CH_O ? FUNC_OUT : FUNC_PASSIVE;
        end
    end
    wire [1:0] state_status = !syntax_ok ? STS_SYNTAX
                            : !(&bit_ok) ? STS_PARAM : STS_OK; // RL8
    wire [1:0] func_status = !syntax_ok ? STS_SYNTAX
                           : !(&func_ok) ? STS_PARAM : STS_OK;
    wire state_apply = do_state_set && state_status == STS_OK;
    wire func_apply = do_func_set && func_status == STS_OK;
    wire parse_now = state_reg == ST_PARSE;

    // ==========================================================
    // port updates
    always_comb begin
        out_state_next = out_state_reg; // RL13
        for (int i = 0; i < NUM_PORTS; i++) begin
            func_next[i] = func_reg[i];
            if (parse_now && func_reg[i] == FUNC_OUT) begin // RL6
                if (state_apply && has[i])
                    out_state_next[i] = val[i] == CH_1; // RL5
                if (do_act && sel_port[i])
                    out_state_next[i] = 1'b1; // RL11
                if (do_deact && sel_port[i])
                    out_state_next[i] = 1'b0; // RL9 RL10
            end
            if (parse_now && func_apply && has[i])
                func_next[i] = func_val[i]; // RL12
        end
    end

    // ==========================================================
    // reply build
    logic [7:0] qry_ch [0:NUM_PORTS-1];
    always_comb begin
        for (int i = 0; i < NUM_PORTS; i++) begin
            if (do_func_query)
                qry_ch[i] = func_reg[i] == FUNC_IN ? CH_I
                          : func_reg[i] == FUNC_OUT ? CH_O : CH_P;
            else if (func_reg[i] == FUNC_OUT)
                qry_ch[i] = out_state_reg[i] ? CH_1 : CH_0; // RL2 RL4
            else
                qry_ch[i] = func_reg[i] == FUNC_IN ? CH_I : CH_P; // RL2
        end
        for (int k = 0; k < REPLY_MAX; k++)
            reply_next[k] = CH_CR;
        reply_next[POS_OP0] = CH_O;
        reply_next[POS_OP1] = is_func_cmd ? CH_F : CH_A;
        rlen_next = RLEN_NONE;
        if (do_state_query || do_func_query) begin
            reply_next[POS_ARG] = CH_SP; // RL1
            reply_next[POS_F1_S] = CH_S;
            reply_next[POS_F1_NUM] = CH_1;
            reply_next[POS_F1_EQ] = CH_EQ;
            reply_next[POS_F1_VAL] = qry_ch[0];
            reply_next[POS_SEP] = CH_SEMI;
            reply_next[POS_F2_S] = CH_S;
            reply_next[POS_F2_NUM] = CH_2;
            reply_next[POS_F2_EQ] = CH_EQ;
            reply_next[POS_F2_VAL] = qry_ch[1];
            rlen_next = RLEN_QUERY;
        end else if (do_state_set || do_func_set) begin
            reply_next[POS_ARG] = CH_EQ; // RL8
            reply_next[POS_ACK_D0] = CH_0;
            reply_next[POS_ACK_D1] = CH_0
                | {6'h00, do_func_set ? func_status : state_status};
            reply_next[POS_ACK_CR] = CH_CR;
            rlen_next = RLEN_ACK;
        end
    end

    // ==========================================================
    // control flow
    wire last_sent = reply_ready && idx_reg == rlen_reg;
    always_comb begin
        case (state_reg)
            ST_RECV: state_next = take_cr ? ST_PARSE : ST_RECV;
            ST_PARSE: state_next = rlen_next != RLEN_NONE ? ST_SEND
                                                          : ST_RECV;
            ST_SEND: state_next = last_sent ? ST_RECV : ST_SEND;
            default: state_next = ST_RECV;
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= ST_RECV;
            line_ready_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            line_ready_reg <= state_next == ST_RECV && !take_cr;
        end
    end

    // line buffer needs no reset; length gates every read
    always_ff @(posedge ref_clk) begin
        if (take_chr && has_room)
            line_mem[len_reg[3:0]] <= line_in.data;
        if (parse_now)
            reply_mem <= reply_next;
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            len_reg <= 5'h00;
            overflow_reg <= 1'b0;
        end else if (parse_now) begin
            len_reg <= 5'h00;
            overflow_reg <= 1'b0;
        end else if (take_chr) begin
            len_reg <= has_room ? len_reg + 5'h01 : len_reg;
            overflow_reg <= overflow_reg || !has_room;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rlen_reg <= RLEN_NONE;
            idx_reg <= 4'h0;
            reply_reg <= '0;
        end else if (parse_now) begin
            rlen_reg <= rlen_next;
            idx_reg <= 4'h1;
            reply_reg <= '{valid: rlen_next != RLEN_NONE,
                           data: reply_next[POS_OP0]};
        end else if (state_reg == ST_SEND && reply_ready) begin
            idx_reg <= idx_reg + 4'h1;
            reply_reg <= '{valid: !last_sent, data: reply_mem[idx_reg]};
        end
    end

    // ==========================================================
    // ports and pins; pins follow state one cycle later
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_state_reg <= {NUM_PORTS{STATE_RESET[0]}};
            func_reg <= '{NUM_PORTS{FUNC_RESET}};
            drive_reg <= '0;
            drive_en_reg <= '0;
        end else begin
            out_state_reg <= out_state_next;
            func_reg <= func_next;
            for (int i = 0; i < NUM_PORTS; i++) begin
                drive_reg[i] <= out_state_reg[i] ^ port_invert[i]; // RL3
                drive_en_reg[i] <= func_reg[i] == FUNC_OUT;
            end
        end
    end

    assign line_ready = line_ready_reg;
    assign reply_out = reply_reg;
    assign port_drive = drive_reg;
    assign port_drive_en = drive_en_reg;

endmodule

//--- testbench/swio_cmd_monitor.sv
/*
 * port checks for the switching port command handler.
 * assumes it is bound to swio_cmd and sees only that module's ports.
 */
module swio_cmd_monitor
    import swio_cmd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire byte_beat_t line_in,
    input wire logic line_ready,
    input wire byte_beat_t reply_out,
    input wire logic reply_ready,
    input wire logic [NUM_PORTS-1:0] port_invert,
    input wire logic [NUM_PORTS-1:0] port_drive,
    input wire logic [NUM_PORTS-1:0] port_drive_en
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // line and reply flow
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    wire cr_taken = line_ready && line_in.valid && line_in.data == CH_CR;

    chk_reply_hold: assert property (
        reply_out.valid && !reply_ready |=>
        reply_out.valid && $stable(reply_out.data))
        else $error("reply byte changed before it was taken");
    chk_ready_excl: assert property (
        line_ready |-> !reply_out.valid)
        else $error("line input open while a reply stands");
    chk_cr_latency: assert property (
        cr_taken |=> !line_ready ##[1:3] (reply_out.valid || line_ready))
        else $error("no reply and no return to idle after line end");
    chk_first_char: assert property (
        $rose(reply_out.valid) |-> reply_out.data == CH_O)
        else $error("reply does not open with the command letter");
    chk_reply_last: assert property (
        reply_out.valid && reply_ready && reply_out.data == CH_CR
        |=> !reply_out.valid && line_ready)
        else $error("handler not idle after reply end");
    chk_ready_boot: assert property (
        $fell(sys_rst) |=> line_ready)
        else $error("line input not open after reset");

    // ==========================================================
    // pins: only a parsed command or a port_invert change may move them
    chk_pins_hold: assert property (
        (line_ready && $stable(port_invert)) [*3] |=> $stable(port_drive))
        else $error("pin level moved with no command");
    chk_en_change: assert property (
        $changed(port_drive_en) |-> !line_ready)
        else $error("port function changed outside a command");
endmodule

bind swio_cmd swio_cmd_monitor swio_cmd_monitor_i (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .line_in(line_in),
    .line_ready(line_ready),
    .reply_out(reply_out),
    .reply_ready(reply_ready),
    .port_invert(port_invert),
    .port_drive(port_drive),
    .port_drive_en(port_drive_en)
);

//--- testbench/host_model.sv
/*
 * host controller model: sends text lines byte by byte, collects replies.
 * assumes the handler takes a byte only at an edge with line_ready high.
 */
module host_model
    import swio_cmd_pkg::*;
(
    input wire logic ref_clk,
    output byte_beat_t line_in,
    input wire logic line_ready,
    input wire byte_beat_t reply_out,
    output logic reply_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic stall;
    initial begin
        line_in = '{1'b0, 8'h00};
        reply_ready = 1'b0;
        stall = 1'b0;
    end
    // ==========================================================
    // byte held until taken; idle data inverted so stale bytes show
    task automatic put(input logic [7:0] b);
        int n;
        n = 0;
        @(posedge ref_clk);
        line_in <= '{1'b1, b};
        do begin
            @(posedge ref_clk);
            n++;
        end while (line_ready !== 1'b1 && n < 200);
        line_in <= '{1'b0, ~b};
    endtask
    // leading zero bytes of the packed text are skipped
    task automatic send_line(input logic [127:0] s);
        for (int i = 15; i >= 0; i--) begin
            if (s[i*8+:8] != 8'h00) put(s[i*8+:8]);
        end
        put(CH_CR);
    endtask
    task automatic idle();
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (line_ready !== 1'b1 && n < 50);
    endtask
    // stall mode accepts every second cycle pair only
    task automatic get_reply(output logic [103:0] r);
        r = '0;
        for (int n = 0; n < 400; n++) begin
            reply_ready <= !stall || n[1];
            @(posedge ref_clk);
            if (reply_out.valid === 1'b1 && reply_ready === 1'b1) begin
                r = {r[95:0], reply_out.data};
                if (reply_out.data === CH_CR) break;
            end
        end
        reply_ready <= 1'b0;
    endtask
endmodule

//--- testbench/testbench.sv
/*
 * self-checking bench for the switching port command handler.
 * assumes the host model and the bound port checker are compiled too.
 */
module testbench
    import swio_cmd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, sys_rst, line_ready, reply_ready;
    byte_beat_t line_in, reply_out;
    logic [1:0] port_invert, port_drive, port_drive_en;
    logic [103:0] rep;
    int n_errors = 0;
    int compares = 0;
    typedef struct {
        logic [127:0] cmd;
        logic [1:0] inv;
        logic [103:0] rep;
        logic [1:0] en;
        logic [1:0] drv;
    } row_t;
    // subsets listed in ascending port order only
    row_t rows [15] = '{
        '{"OA?", 2'h0, "OA S1=P;S2=P\r", 2'h0, 2'h0},
        '{"OA S1=1", 2'h0, "OA=00\r", 2'h0, 2'h0},
        '{"OF S1=O;S2=I", 2'h0, "OF=00\r", 2'h1, 2'h0},
        '{"OA S1=1;S2=1", 2'h0, "OA=00\r", 2'h1, 2'h1},
        '{"OA?", 2'h1, "OA S1=1;S2=I\r", 2'h1, 2'h0},
        '{"OF S2=O", 2'h1, "OF=00\r", 2'h3, 2'h0},
        '{"OD1", 2'h1, 104'h0, 2'h3, 2'h1},
        '{"OA2", 2'h1, 104'h0, 2'h3, 2'h3},
        '{"OA?", 2'h1, "OA S1=0;S2=1\r", 2'h3, 2'h3},
        '{"OA S2=0", 2'h1, "OA=00\r", 2'h3, 2'h1},
        '{"OA S1-1", 2'h1, "OA=01\r", 2'h3, 2'h1},
        '{"OA S1=1;S2=7", 2'h1, "OA=02\r", 2'h3, 2'h1},
        '{"OD3", 2'h1, 104'h0, 2'h3, 2'h1},
        '{"OA", 2'h0, "OA=00\r", 2'h3, 2'h0},
        '{"OA1", 2'h0, 104'h0, 2'h3, 2'h1}
    };

    swio_cmd swio_cmd_i (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .line_in(line_in),
        .line_ready(line_ready),
        .reply_out(reply_out),
        .reply_ready(reply_ready),
        .port_invert(port_invert),
        .port_drive(port_drive),
        .port_drive_en(port_drive_en)
    );
    host_model host_i (
        .ref_clk(ref_clk),
        .line_in(line_in),
        .line_ready(line_ready),
        .reply_out(reply_out),
        .reply_ready(reply_ready)
    );

    // ==========================================================
    // clock, compare and verdict
    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;
    task automatic check(input logic [103:0] seen, input logic [103:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results();
        if (n_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // a row takes well under 200 cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        results();
    end

    // ==========================================================
    // table run, then stalled reply and mid-run reset
    initial begin
        sys_rst = 1'b1;
        port_invert = 2'h0;
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        for (int i = 0; i < 15; i++) begin
            port_invert <= rows[i].inv;
            host_i.send_line(rows[i].cmd);
            if (rows[i].rep != '0) begin
                host_i.get_reply(rep);
                check(rep, rows[i].rep);
            end else host_i.idle();
            repeat (4) @(posedge ref_clk);
            check(104'(port_drive_en), 104'(rows[i].en));
            check(104'(port_drive), 104'(rows[i].drv));
        end
        host_i.stall = 1'b1;
        host_i.send_line("OA?");
        host_i.get_reply(rep);
        check(rep, "OA S1=1;S2=0\r");
        host_i.stall = 1'b0;
        host_i.send_line("OF?");
        host_i.get_reply(rep);
        check(rep, "OF S1=O;S2=O\r");
        // 17 characters are dropped whole; a bare line end must not replay
        host_i.put(CH_O);
        host_i.send_line("A S1=0;S2=0;S1=0");
        host_i.idle();
        host_i.send_line(128'h0);
        host_i.idle();
        check(104'(line_ready), 104'h1);
        check(104'(port_drive), 104'h1);
        sys_rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check(104'(port_drive_en), 104'h0);
        sys_rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        host_i.send_line("OA?");
        host_i.get_reply(rep);
        check(rep, "OA S1=P;S2=P\r");
        check(104'(port_drive), 104'h0);
        results();
    end
endmodule
